/* core/scic_pkg.sv */
/*
 * Package of the smart card interface control block: timing constants,
 * reset values, state encodings and the signal bundles shared by the design.
 * Assumes a 10 MHz system clock; all times are turned into cycle counts here.
 */
package scic_pkg;

	// ------------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------------
	localparam int CLK_FREQ_KHZ       = 10000;          // System clock, 10 MHz
	localparam int DEBOUNCE_TIME_US   = 8000;           // Insertion debounce, 8 ms
	localparam int DEBOUNCE_CYCLES    = (DEBOUNCE_TIME_US * CLK_FREQ_KHZ) / 1000;
	localparam int SEQ_STEP_TIME_US   = 50;             // Gap between sequence steps
	localparam int SEQ_STEP_CYCLES    = (SEQ_STEP_TIME_US * CLK_FREQ_KHZ) / 1000;
	localparam int STEP_CNT_W         = 16;             // Width of the step timer

	// ------------------------------------------------------------------
	// Line relay layout, reset values and divide codes
	// ------------------------------------------------------------------
	localparam int LINE_COUNT         = 3;              // Data, aux c4, aux c8
	localparam int LINE_DATA          = 0;              // Bit position of the data line
	localparam int LINE_AUX_C4        = 1;              // Bit position of aux c4
	localparam int LINE_AUX_C8        = 2;              // Bit position of aux c8
	localparam logic RST_OE_N         = 1'h1;           // Lines released after reset
	localparam logic RST_INT_N        = 1'h1;           // Interrupt inactive after reset
	localparam logic [1:0] DIV_BY_1   = 2'h0;           // Divide-select codes {b,a}
	localparam logic [1:0] DIV_BY_2   = 2'h1;
	localparam logic [1:0] DIV_BY_4   = 2'h2;
	localparam logic [1:0] DIV_BY_8   = 2'h3;

	// ------------------------------------------------------------------
	// Session sequencer states
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE     = 3'h0,   // Card unpowered
		ST_POWER    = 3'h1,   // Card supply on
		ST_DATA     = 3'h2,   // Serial lines enabled
		ST_CLOCK    = 3'h3,   // Card clock running
		ST_ACTIVE   = 3'h4,   // Reset follows host
		ST_D_RESET  = 3'h5,   // Deactivation: reset low
		ST_D_CLOCK  = 3'h6,   // Deactivation: clock stopped
		ST_D_DATA   = 3'h7    // Deactivation: lines released
	} scic_state_e;

	// Relay direction of one bidirectional line
	typedef enum logic [1:0] {
		RL_IDLE     = 2'h0,   // Nobody drives
		RL_HOST     = 2'h1,   // Host drives, copied to card
		RL_CARD     = 2'h2,   // Card drives, copied to host
		RL_SETTLE   = 2'h3    // Both released, wait for both high
	} scic_relay_e;

	// Host control pins and presence and supply monitors, sampled together
	typedef struct packed {
		logic       act_req_n;    // Activation request, active low
		logic       reset;        // Host reset level for the card
		logic       clock;        // Host clock
		logic [1:0] div_sel;      // {select_b, select_a}
		logic       sel_5v;       // High selects 5 V, low 3 V
		logic       det_low_n;    // Presence, card present when low
		logic       det_high;     // Presence, card present when high
		logic       overload;     // Card supply overload monitor
		logic       undervolt;    // Host supply below lockout
	} scic_ctrl_s;

endpackage

/* core/scic_top.sv */
/*
 * Smart card interface control: activation and deactivation sequencing,
 * card clock division, reset relay, three bidirectional line relays,
 * presence debounce and the active-low interrupt.
 * Assumes every pin input is asynchronous to clk_sys_in and is synchronised
 * here; the analog supply, overload and lockout detectors are outside and
 * report as plain levels. Two-way lines are open drain: out plus oe_n.
 */
`timescale 1ns/100ps

module scic_top
	import scic_pkg::*;
#(
	parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES,   // Shorten for simulation
	parameter int STEP_LEN     = SEQ_STEP_CYCLES
) (
	// Clock and reset
	input  wire logic clk_sys_in,
	input  wire logic rst_n_in,
	// Host control pins
	input  wire logic activation_request_n_in,
	input  wire logic host_reset_in,
	input  wire logic host_clock_in,
	input  wire logic clock_divide_select_a_in,
	input  wire logic clock_divide_select_b_in,
	input  wire logic supply_voltage_select_in,
	// Presence and supply monitors
	input  wire logic card_detect_low_n_in,
	input  wire logic card_detect_high_in,
	input  wire logic supply_overload_in,
	input  wire logic undervoltage_in,
	// Host-side two-way lines
	input  wire logic host_data_line_in,
	output logic      host_data_line_out,
	output logic      host_data_line_oe_n_out,
	input  wire logic host_aux_c4_line_in,
	output logic      host_aux_c4_line_out,
	output logic      host_aux_c4_line_oe_n_out,
	input  wire logic host_aux_c8_line_in,
	output logic      host_aux_c8_line_out,
	output logic      host_aux_c8_line_oe_n_out,
	// Card-side two-way lines
	input  wire logic card_data_line_in,
	output logic      card_data_line_out,
	output logic      card_data_line_oe_n_out,
	input  wire logic card_aux_c4_line_in,
	output logic      card_aux_c4_line_out,
	output logic      card_aux_c4_line_oe_n_out,
	input  wire logic card_aux_c8_line_in,
	output logic      card_aux_c8_line_out,
	output logic      card_aux_c8_line_oe_n_out,
	// Card-side outputs
	output logic      card_clock_out,
	output logic      card_reset_out,
	output logic      card_supply_out,
	output logic      card_supply_5v_out,
	// Host interrupt
	output logic      interrupt_n_out
);

	// ------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------
	if (DEBOUNCE_LEN < 1 || DEBOUNCE_LEN >= 2 ** 24) begin : g_bad_debounce
		$error("DEBOUNCE_LEN out of range");
	end
	if (STEP_LEN < 1 || STEP_LEN >= 2 ** STEP_CNT_W) begin : g_bad_step
		$error("STEP_LEN out of range");
	end

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	scic_ctrl_s                  ctrl_raw;
	scic_ctrl_s                  ctrl_meta;
	scic_ctrl_s                  ctrl;
	logic [LINE_COUNT-1:0]       host_raw;
	logic [LINE_COUNT-1:0]       card_raw;
	logic [LINE_COUNT-1:0]       host_meta;
	logic [LINE_COUNT-1:0]       card_meta;
	logic [LINE_COUNT-1:0]       host_lvl;
	logic [LINE_COUNT-1:0]       card_lvl;
	logic [LINE_COUNT-1:0]       host_oe_n;
	logic [LINE_COUNT-1:0]       card_oe_n;
	logic                        act_req_n_prev;
	logic                        host_clock_prev;
	logic                        raw_present;
	logic                        card_present;
	logic [23:0]                 debounce_cnt;
	scic_state_e                 state;
	scic_state_e                 next_state;
	logic [STEP_CNT_W-1:0]       step_cnt;
	logic                        step_done;
	logic                        request_edge;
	logic                        fault;
	logic                        fault_event;
	logic                        fault_latched;
	logic                        lines_enabled;
	logic                        clock_enabled;
	logic [1:0]                  div_cnt;
	logic                        host_clock_rise;

	// Half period, in host clock rising edges minus one, per divide code
	function automatic logic [1:0] div_half_last(input logic [1:0] sel);
		case (sel)
			DIV_BY_2: div_half_last = 2'h0;
			DIV_BY_4: div_half_last = 2'h1;
			DIV_BY_8: div_half_last = 2'h3;
			default:  div_half_last = 2'h0;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------
	// Gather pins into bundles
	assign ctrl_raw = '{act_req_n: activation_request_n_in, reset: host_reset_in,
		clock: host_clock_in,
		div_sel: {clock_divide_select_b_in, clock_divide_select_a_in},
		sel_5v: supply_voltage_select_in, det_low_n: card_detect_low_n_in,
		det_high: card_detect_high_in, overload: supply_overload_in,
		undervolt: undervoltage_in};
	assign host_raw = {host_aux_c8_line_in, host_aux_c4_line_in, host_data_line_in};
	assign card_raw = {card_aux_c8_line_in, card_aux_c4_line_in, card_data_line_in};

	// Two flip-flops on every pin; lockout assumed active until sampled
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_meta <= '{act_req_n: 1'h1, det_low_n: 1'h1, undervolt: 1'h1, default: 1'h0};
			ctrl      <= '{act_req_n: 1'h1, det_low_n: 1'h1, undervolt: 1'h1, default: 1'h0};
			host_meta <= '1;
			host_lvl  <= '1;
			card_meta <= '1;
			card_lvl  <= '1;
		end else begin
			ctrl_meta <= ctrl_raw;
			ctrl      <= ctrl_meta;
			host_meta <= host_raw;
			host_lvl  <= host_meta;
			card_meta <= card_raw;
			card_lvl  <= card_meta;
		end
	end

	// Previous levels for edge detection
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			act_req_n_prev  <= 1'h1;
			host_clock_prev <= 1'h0;
		end else begin
			act_req_n_prev  <= ctrl.act_req_n;
			host_clock_prev <= ctrl.clock;
		end
	end

	// ------------------------------------------------------------------
	// Card presence
	// ------------------------------------------------------------------
	assign raw_present = !ctrl.det_low_n || ctrl.det_high;

	// Insertion must hold for the debounce time; removal counts at once
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			debounce_cnt <= '0;
			card_present <= 1'h0;
		end else if (!raw_present) begin
			debounce_cnt <= '0;
			card_present <= 1'h0;
		end else if (!card_present) begin
			if (debounce_cnt == 24'(DEBOUNCE_LEN - 1)) begin
				card_present <= 1'h1;
			end else begin
				debounce_cnt <= debounce_cnt + 24'h1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Session sequencer
	// ------------------------------------------------------------------
	assign request_edge = act_req_n_prev && !ctrl.act_req_n;
	assign fault        = !card_present || ctrl.overload || ctrl.undervolt;
	assign step_done    = (step_cnt == STEP_CNT_W'(STEP_LEN - 1));
	assign fault_event  = fault && (state != ST_IDLE);

	// Next state: steps advance on the step timer, faults and release unwind
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (request_edge && !fault) begin
					next_state = ST_POWER;
				end
			end
			ST_POWER, ST_DATA, ST_CLOCK: begin
				if (fault || ctrl.act_req_n) begin
					next_state = ST_D_RESET;
				end else if (step_done) begin
					next_state = scic_state_e'(state + 3'h1);
				end
			end
			ST_ACTIVE: begin
				if (fault || ctrl.act_req_n) begin
					next_state = ST_D_RESET;
				end
			end
			ST_D_RESET, ST_D_CLOCK: begin
				if (step_done) begin
					next_state = scic_state_e'(state + 3'h1);
				end
			end
			ST_D_DATA: begin
				if (step_done) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// State register and step timer
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state    <= ST_IDLE;
			step_cnt <= '0;
		end else begin
			state    <= next_state;
			step_cnt <= (next_state != state || step_done) ? '0 : step_cnt + 1'h1;
		end
	end

	// Fault flag: set by an automatic deactivation, cleared when host lets go
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fault_latched <= 1'h0;
		end else if (fault_event && !ctrl.act_req_n) begin          // Host release wins over a fault
			fault_latched <= 1'h1;
		end else if (ctrl.act_req_n) begin
			fault_latched <= 1'h0;
		end
	end

	// Lines and clock stay off whenever the card supply is off, even mid-unwind
	assign lines_enabled = (state >= ST_DATA) && (state != ST_D_DATA) && !ctrl.undervolt
		&& card_supply_out;
	assign clock_enabled = (state >= ST_CLOCK) && (state <= ST_D_RESET) && !ctrl.undervolt
		&& card_supply_out;

	// ------------------------------------------------------------------
	// Supply, reset and interrupt outputs
	// ------------------------------------------------------------------
	// Supply rises only in the power step, so a lockout cut stays off until the next session
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			card_supply_out    <= 1'h0;
			card_supply_5v_out <= 1'h0;
		end else begin
			card_supply_out <= (state == ST_POWER || (card_supply_out && state != ST_IDLE))
				&& !ctrl.undervolt;
			if (state == ST_IDLE) begin
				card_supply_5v_out <= ctrl.sel_5v;
			end
		end
	end

	// Reset follows host only once the session is fully up
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			card_reset_out <= 1'h0;
		end else begin
			card_reset_out <= (state == ST_ACTIVE) && !ctrl.undervolt && ctrl.reset;
		end
	end

	// Interrupt low on presence, overload or automatic deactivation
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			interrupt_n_out <= RST_INT_N;
		end else begin
			interrupt_n_out <= !(card_present || ctrl.overload || fault_latched);
		end
	end

	// ------------------------------------------------------------------
	// Card clock divider
	// ------------------------------------------------------------------
	assign host_clock_rise = ctrl.clock && !host_clock_prev;

	// Host clock is sampled, so it must stay well under half the system rate
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			card_clock_out <= 1'h0;
			div_cnt        <= 2'h0;
		end else if (!clock_enabled) begin
			card_clock_out <= 1'h0;
			div_cnt        <= 2'h0;
		end else if (ctrl.div_sel == DIV_BY_1) begin
			card_clock_out <= ctrl.clock;
		end else if (host_clock_rise) begin
			if (div_cnt == div_half_last(ctrl.div_sel)) begin
				card_clock_out <= !card_clock_out;
				div_cnt        <= 2'h0;
			end else begin
				div_cnt <= div_cnt + 2'h1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Bidirectional line relays
	// ------------------------------------------------------------------
	for (genvar i = 0; i < LINE_COUNT; i++) begin : g_relay
		scic_relay_e dir;

		// Whoever pulls low first owns the line until it lets go
		always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				dir          <= RL_IDLE;
				host_oe_n[i] <= RST_OE_N;
				card_oe_n[i] <= RST_OE_N;
			end else if (!lines_enabled) begin
				dir          <= RL_IDLE;
				host_oe_n[i] <= RST_OE_N;
				card_oe_n[i] <= RST_OE_N;
			end else begin
				case (dir)
					RL_IDLE: begin
						if (!host_lvl[i]) begin
							dir          <= RL_HOST;
							card_oe_n[i] <= 1'h0;
						end else if (!card_lvl[i]) begin
							dir          <= RL_CARD;
							host_oe_n[i] <= 1'h0;
						end
					end
					RL_HOST: begin
						if (host_lvl[i]) begin
							dir          <= RL_SETTLE;
							card_oe_n[i] <= 1'h1;
						end
					end
					RL_CARD: begin
						if (card_lvl[i]) begin
							dir          <= RL_SETTLE;
							host_oe_n[i] <= 1'h1;
						end
					end
					RL_SETTLE: begin
						// Avoid echoing our own low back to its source
						if (host_lvl[i] && card_lvl[i]) begin
							dir <= RL_IDLE;
						end
					end
					default: dir <= RL_IDLE;
				endcase
			end
		end
	end

	// Open-drain drive: the output level is always low
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			host_data_line_out   <= 1'h0;
			host_aux_c4_line_out <= 1'h0;
			host_aux_c8_line_out <= 1'h0;
			card_data_line_out   <= 1'h0;
			card_aux_c4_line_out <= 1'h0;
			card_aux_c8_line_out <= 1'h0;
		end else begin
			host_data_line_out   <= 1'h0;
			host_aux_c4_line_out <= 1'h0;
			host_aux_c8_line_out <= 1'h0;
			card_data_line_out   <= 1'h0;
			card_aux_c4_line_out <= 1'h0;
			card_aux_c8_line_out <= 1'h0;
		end
	end

	// Enables come straight from the relay flip-flops
	assign host_data_line_oe_n_out   = host_oe_n[LINE_DATA];
	assign host_aux_c4_line_oe_n_out = host_oe_n[LINE_AUX_C4];
	assign host_aux_c8_line_oe_n_out = host_oe_n[LINE_AUX_C8];
	assign card_data_line_oe_n_out   = card_oe_n[LINE_DATA];
	assign card_aux_c4_line_oe_n_out = card_oe_n[LINE_AUX_C4];
	assign card_aux_c8_line_oe_n_out = card_oe_n[LINE_AUX_C8];

endmodule

/* sim/scic_card_model.sv */
/*
 * Card-side partner of scic_top: pull-ups on the three card lines, a card
 * that pulls a line low on command, and a card clock period meter.
 * Assumes the bench resolves the host-side wires itself.
 */
`timescale 1ns/100ps

module scic_card_model (
	// Clock and card power
	input  wire logic       clk_sys_in,
	input  wire logic       card_supply_in,
	input  wire logic       card_clock_in,
	// Device drive per line, bit 0 data, 1 aux c4, 2 aux c8
	input  wire logic [2:0] dev_oe_n_in,
	input  wire logic [2:0] dev_out_in,
	// Card drive command and observed results
	input  wire logic [2:0] pull_in,
	output logic      [2:0] wire_out,
	output int              period_out
);
	int   cnt    = 0;
	logic clk_q  = 1'h0;

	// Pull-ups hold released lines high; an unpowered card cannot pull
	assign wire_out = ~(pull_in & {3{card_supply_in}}) & (dev_oe_n_in | dev_out_in);

	// System cycles between card clock rising edges
	always @(posedge clk_sys_in) begin
		clk_q <= card_clock_in;
		cnt <= cnt + 1;
		if (card_clock_in && !clk_q) begin
			period_out <= cnt;
			cnt <= 1;
		end
	end
	initial period_out = 0;
endmodule

/* sim/scic_top_asserts.sv */
/*
 * Port-level checker of scic_top, bound into every instance.
 * Assumes short debounce and step lengths handed on by the bind.
 */
`timescale 1ns/100ps

module scic_top_asserts #(
	parameter int DEBOUNCE_LEN = 20,
	parameter int STEP_LEN     = 4
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// Host, monitor and card line inputs
	input wire logic activation_request_n_in,
	input wire logic card_detect_low_n_in,
	input wire logic card_detect_high_in,
	input wire logic supply_overload_in,
	input wire logic undervoltage_in,
	input wire logic host_data_line_in,
	input wire logic card_aux_c4_line_in,
	// Device outputs
	input wire logic card_data_line_oe_n_out,
	input wire logic host_aux_c4_line_oe_n_out,
	input wire logic card_clock_out,
	input wire logic card_reset_out,
	input wire logic card_supply_out,
	input wire logic interrupt_n_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	int pres_cnt;
	int off_cnt;

	// Unbroken presence and request-high run lengths
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pres_cnt <= 0;
			off_cnt <= 0;
		end else begin
			pres_cnt <= (!card_detect_low_n_in || card_detect_high_in) ? pres_cnt + 1 : 0;
			off_cnt <= activation_request_n_in ? off_cnt + 1 : 0;
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_uv_off;
		undervoltage_in [*4] |-> !card_supply_out && !card_clock_out && card_data_line_oe_n_out;
	endproperty
	a_uv_off: assert property (p_uv_off) else $error("card pins live in lockout");
	property p_idle_int;
		(card_detect_low_n_in && !card_detect_high_in && !supply_overload_in
			&& activation_request_n_in) [*5] |-> interrupt_n_out;
	endproperty
	a_idle_int: assert property (p_idle_int) else $error("interrupt with no card");
	property p_ovl_int;
		supply_overload_in [*4] |-> !interrupt_n_out;
	endproperty
	a_ovl_int: assert property (p_ovl_int) else $error("no interrupt on overload");
	property p_debounce;
		pres_cnt == DEBOUNCE_LEN + 6 |-> !interrupt_n_out;
	endproperty
	a_debounce: assert property (p_debounce) else $error("presence not flagged");
	property p_clk_pow;
		$rose(card_clock_out) || card_reset_out |-> card_supply_out;
	endproperty
	a_clk_pow: assert property (p_clk_pow) else $error("card driven unpowered");
	property p_order;
		$rose(card_supply_out) |-> (!card_clock_out && !card_reset_out) [*4];
	endproperty
	a_order: assert property (p_order) else $error("clock or reset before supply");
	property p_data_relay;
		$fell(card_data_line_oe_n_out) |-> !$past(host_data_line_in, 2);
	endproperty
	a_data_relay: assert property (p_data_relay) else $error("data drive w/o host");
	property p_aux_relay;
		$fell(host_aux_c4_line_oe_n_out) |-> !$past(card_aux_c4_line_in, 2);
	endproperty
	a_aux_relay: assert property (p_aux_relay) else $error("aux drive w/o card");
	property p_start;
		$rose(card_supply_out) |-> !$past(activation_request_n_in, 2);
	endproperty
	a_start: assert property (p_start) else $error("session without request");
	property p_end;
		off_cnt == 3 * STEP_LEN + 10 |-> !card_supply_out && !card_clock_out;
	endproperty
	a_end: assert property (p_end) else $error("session outlives request");

	c_session: cover property ($rose(card_supply_out));
	c_relay: cover property ($fell(card_data_line_oe_n_out));
	c_lockout: cover property (undervoltage_in && $fell(card_supply_out));
endmodule

bind scic_top scic_top_asserts #(.DEBOUNCE_LEN(DEBOUNCE_LEN), .STEP_LEN(STEP_LEN)) scic_top_asserts_i (
	.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
	.activation_request_n_in(activation_request_n_in),
	.card_detect_low_n_in(card_detect_low_n_in), .card_detect_high_in(card_detect_high_in),
	.supply_overload_in(supply_overload_in), .undervoltage_in(undervoltage_in),
	.host_data_line_in(host_data_line_in), .card_aux_c4_line_in(card_aux_c4_line_in),
	.card_data_line_oe_n_out(card_data_line_oe_n_out),
	.host_aux_c4_line_oe_n_out(host_aux_c4_line_oe_n_out),
	.card_clock_out(card_clock_out), .card_reset_out(card_reset_out),
	.card_supply_out(card_supply_out), .interrupt_n_out(interrupt_n_out));

/* sim/tb_scic_top.sv */
/*
 * Self-checking bench of scic_top: presence, sessions, division, relays, faults.
 * Assumes scic_card_model on the card side; host wires are resolved here.
 */
`timescale 1ns/100ps

module tb_scic_top;
	import scic_pkg::*;
	localparam int DEB  = 20;
	localparam int STEP = 4;
	logic       clk_sys_in = 1'h0;
	logic       rst_n_in   = 1'h0;
	scic_ctrl_s ctl;
	logic [2:0] host_pull  = 3'h0;
	logic [2:0] card_pull  = 3'h0;
	logic [2:0] host_w, card_w, h_oe_n, h_out, c_oe_n, c_out;
	logic       card_clk, card_rst, card_sup, card_5v, int_n;
	int         period;
	int         miscompares = 0;
	int         cmp_count   = 0;
	int         hc          = 0;

	// System clock, and a host clock of eight system cycles
	always #50 clk_sys_in = !clk_sys_in;
	always @(posedge clk_sys_in) begin
		hc <= (hc == 3) ? 0 : hc + 1;
		if (hc == 3)
			ctl.clock <= !ctl.clock;
	end
	// Host side open-drain wires with pull-ups
	assign host_w = ~host_pull & (h_oe_n | h_out);

	scic_top #(.DEBOUNCE_LEN(DEB), .STEP_LEN(STEP)) scic_top_i (
		.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.activation_request_n_in(ctl.act_req_n), .host_reset_in(ctl.reset),
		.host_clock_in(ctl.clock), .clock_divide_select_a_in(ctl.div_sel[0]),
		.clock_divide_select_b_in(ctl.div_sel[1]), .supply_voltage_select_in(ctl.sel_5v),
		.card_detect_low_n_in(ctl.det_low_n), .card_detect_high_in(ctl.det_high),
		.supply_overload_in(ctl.overload), .undervoltage_in(ctl.undervolt),
		.host_data_line_in(host_w[0]), .host_data_line_out(h_out[0]),
		.host_data_line_oe_n_out(h_oe_n[0]), .host_aux_c4_line_in(host_w[1]),
		.host_aux_c4_line_out(h_out[1]), .host_aux_c4_line_oe_n_out(h_oe_n[1]),
		.host_aux_c8_line_in(host_w[2]), .host_aux_c8_line_out(h_out[2]),
		.host_aux_c8_line_oe_n_out(h_oe_n[2]), .card_data_line_in(card_w[0]),
		.card_data_line_out(c_out[0]), .card_data_line_oe_n_out(c_oe_n[0]),
		.card_aux_c4_line_in(card_w[1]), .card_aux_c4_line_out(c_out[1]),
		.card_aux_c4_line_oe_n_out(c_oe_n[1]), .card_aux_c8_line_in(card_w[2]),
		.card_aux_c8_line_out(c_out[2]), .card_aux_c8_line_oe_n_out(c_oe_n[2]),
		.card_clock_out(card_clk), .card_reset_out(card_rst), .card_supply_out(card_sup),
		.card_supply_5v_out(card_5v), .interrupt_n_out(int_n));

	scic_card_model scic_card_model_i (.clk_sys_in(clk_sys_in), .card_supply_in(card_sup),
		.card_clock_in(card_clk), .dev_oe_n_in(c_oe_n), .dev_out_in(c_out),
		.pull_in(card_pull), .wire_out(card_w), .period_out(period));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Waits n rising edges, the point where inputs change
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask
	// Waits n edges, then looks at settled outputs
	task automatic look(input int n);
		cyc(n);
		@(negedge clk_sys_in);
	endtask
	task automatic wait_sup(input logic v, input int lim);
		int n;
		n = 0;
		@(negedge clk_sys_in);
		while (card_sup !== v && n < lim) begin
			@(negedge clk_sys_in);
			n++;
		end
		if (n >= lim) begin
			miscompares++;
			stop_test();
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_presence();
		ctl.det_low_n <= 1'h0;
		look(DEB - 6);
		chk(int_n, 1'h1);
		cyc(1);
		ctl.det_low_n <= 1'h1;
		look(8);
		chk(int_n, 1'h1);
		cyc(1);
		ctl.det_low_n <= 1'h0;
		look(DEB - 2);
		chk(int_n, 1'h1);
		look(8);
		chk(int_n, 1'h0);
		cyc(1);
		ctl.det_low_n <= 1'h1;
		look(6);
		chk(int_n, 1'h1);
		cyc(1);
		ctl.det_high <= 1'h1;
		look(DEB + 8);
		chk(int_n, 1'h0);
		cyc(1);
	endtask
	task automatic t_activate(input logic sel);
		ctl.sel_5v <= sel;
		ctl.act_req_n <= 1'h1;
		cyc(6);
		ctl.act_req_n <= 1'h0;
		wait_sup(1'h1, 10);
		chk(card_5v, sel);
		chk({card_clk, card_rst, c_oe_n}, 5'h07);
		look(3 * STEP + 2);
		cyc(1);
		ctl.reset <= 1'h1;
		look(5);
		chk(card_rst, 1'h1);
		cyc(1);
		ctl.reset <= 1'h0;
		look(5);
		chk(card_rst, 1'h0);
		cyc(1);
	endtask
	task automatic t_divide();
		for (int c = 0; c < 4; c++) begin
			ctl.div_sel <= 2'(c);
			look(150);
			chk(period, 32'(8 << c));
			cyc(1);
		end
	endtask
	task automatic t_relay();
		host_pull <= 3'h1;
		look(6);
		chk({host_w, card_w}, 6'h36);
		cyc(1);
		host_pull <= 3'h0;
		// Let the data line settle before the card takes it
		cyc(6);
		card_pull <= 3'h3;
		look(6);
		chk({host_w, card_w}, 6'h24);
		cyc(1);
		card_pull <= 3'h0;
		host_pull <= 3'h4;
		look(6);
		chk({host_w, card_w}, 6'h1b);
		cyc(1);
		host_pull <= 3'h0;
		look(6);
		chk({host_w, card_w}, 6'h3f);
		cyc(1);
	endtask
	task automatic t_deact();
		ctl.reset <= 1'h1;
		cyc(1);
		ctl.act_req_n <= 1'h1;
		wait_sup(1'h0, 3 * STEP + 12);
		chk({card_clk, card_rst, c_oe_n, int_n}, 6'h0e);
		cyc(1);
		ctl.reset <= 1'h0;
	endtask
	task automatic t_refuse();
		ctl.det_high <= 1'h0;
		cyc(8);
		ctl.act_req_n <= 1'h0;
		look(20);
		chk(card_sup, 1'h0);
		cyc(1);
		ctl.det_high <= 1'h1;
		look(DEB + 20);
		chk({card_sup, int_n}, 2'h0);
		cyc(1);
	endtask
	task automatic t_fault();
		t_activate(1'h0);
		ctl.overload <= 1'h1;
		look(5);
		chk(int_n, 1'h0);
		wait_sup(1'h0, 3 * STEP + 12);
		cyc(1);
		ctl.overload <= 1'h0;
		t_activate(1'h1);
		ctl.det_high <= 1'h0;
		wait_sup(1'h0, 3 * STEP + 12);
		look(10);
		chk(int_n, 1'h0);
		cyc(1);
		ctl.act_req_n <= 1'h1;
		look(8);
		chk(int_n, 1'h1);
		cyc(1);
		ctl.overload <= 1'h1;
		look(5);
		chk(int_n, 1'h0);
		cyc(1);
		ctl.overload <= 1'h0;
		look(5);
		chk(int_n, 1'h1);
		cyc(1);
		ctl.det_high <= 1'h1;
		cyc(DEB + 10);
	endtask
	task automatic t_lockout();
		t_activate(1'h1);
		ctl.undervolt <= 1'h1;
		look(5);
		chk({card_sup, card_clk, card_rst, c_oe_n}, 6'h07);
		cyc(1);
		ctl.undervolt <= 1'h0;
		ctl.act_req_n <= 1'h1;
		cyc(10);
	endtask

	// Main sequence
	initial begin
		ctl = '{act_req_n: 1'h1, det_low_n: 1'h1, div_sel: 2'h0, default: 1'h0};
		cyc(20);
		rst_n_in <= 1'h1;
		cyc(4);
		t_presence();
		t_activate(1'h1);
		t_divide();
		t_relay();
		t_deact();
		t_refuse();
		t_fault();
		t_lockout();
		stop_test();
	end
endmodule
